/* design/pss_shifter.v */
// Eight-stage parallel-in serial-out shifter, sampled on clk_i.
// Assumes every pin is asynchronous to clk_i; all but rstn_i are synchronised here.
// Limitation: a pin level shorter than two clk_i periods may be lost.

`timescale 1ns/1ps
`default_nettype none

`include "pss_consts.vh"

module pss_shifter (
  input wire clk_i,
  input wire rstn_i,
  input wire shift_or_load_n_i,
  input wire shift_clock_i,
  input wire shift_clock_inhibit_i,
  input wire serial_in_i,
  input wire [`PSS_STAGES-1:0] par_data_i,
  output wire serial_out_o,
  output wire serial_out_complement_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Rising edge between the previous and the current accepted level
  function pss_rise;
    input cur;
    input prev;
    begin
      pss_rise = cur & ~prev;
    end
  endfunction

  // ----------------------------------------------------------------
  // Load pin synchroniser
  // ----------------------------------------------------------------
  reg load_s1_r;
  reg load_s2_r;
  reg load_s3_r;
  reg load_n_r;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      load_s1_r <= `PSS_LOAD_IDLE;
      load_s2_r <= `PSS_LOAD_IDLE;
      load_s3_r <= `PSS_LOAD_IDLE;
    end else begin
      load_s1_r <= shift_or_load_n_i;
      load_s2_r <= load_s1_r;
      load_s3_r <= load_s2_r;
    end
  end

  // A level counts once the second and third flops agree
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      load_n_r <= `PSS_LOAD_IDLE;
    end else if (load_s2_r == load_s3_r) begin
      load_n_r <= load_s3_r;
    end
  end

  // ----------------------------------------------------------------
  // Shift clock pin synchroniser
  // ----------------------------------------------------------------
  reg sclk_s1_r;
  reg sclk_s2_r;
  reg sclk_s3_r;
  reg sclk_lvl_r;
  reg sclk_prev_r;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_s1_r <= `PSS_SCLK_IDLE;
      sclk_s2_r <= `PSS_SCLK_IDLE;
      sclk_s3_r <= `PSS_SCLK_IDLE;
    end else begin
      sclk_s1_r <= shift_clock_i;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
    end
  end

  // Reset to the idle level, so no false edge follows reset
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_lvl_r <= `PSS_SCLK_IDLE;
      sclk_prev_r <= `PSS_SCLK_IDLE;
    end else begin
      sclk_prev_r <= sclk_lvl_r;
      if (sclk_s2_r == sclk_s3_r) begin
        sclk_lvl_r <= sclk_s3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Inhibit pin synchroniser
  // ----------------------------------------------------------------
  reg inhibit_s1_r;
  reg inhibit_s2_r;
  reg inhibit_s3_r;
  reg inhibit_lvl_r;
  reg inhibit_prev_r;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inhibit_s1_r <= `PSS_INHIBIT_IDLE;
      inhibit_s2_r <= `PSS_INHIBIT_IDLE;
      inhibit_s3_r <= `PSS_INHIBIT_IDLE;
    end else begin
      inhibit_s1_r <= shift_clock_inhibit_i;
      inhibit_s2_r <= inhibit_s1_r;
      inhibit_s3_r <= inhibit_s2_r;
    end
  end

  // Reset to the idle level, so no false edge follows reset
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inhibit_lvl_r <= `PSS_INHIBIT_IDLE;
      inhibit_prev_r <= `PSS_INHIBIT_IDLE;
    end else begin
      inhibit_prev_r <= inhibit_lvl_r;
      if (inhibit_s2_r == inhibit_s3_r) begin
        inhibit_lvl_r <= inhibit_s3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parallel data synchroniser
  // ----------------------------------------------------------------
  // No reset: the value only matters once a load takes it
  reg [`PSS_STAGES-1:0] dat_s1_r;
  reg [`PSS_STAGES-1:0] dat_s2_r;
  reg [`PSS_STAGES-1:0] dat_s3_r;
  reg [`PSS_STAGES-1:0] dat_r;

  always @(posedge clk_i) begin
    dat_s1_r <= par_data_i;
    dat_s2_r <= dat_s1_r;
    dat_s3_r <= dat_s2_r;
  end

  always @(posedge clk_i) begin
    if (dat_s2_r == dat_s3_r) begin
      dat_r <= dat_s3_r;
    end
  end

  // ----------------------------------------------------------------
  // Serial input synchroniser
  // ----------------------------------------------------------------
  // Same depth as the controls, so data and its strobe line up
  reg sin_s1_r;
  reg sin_s2_r;
  reg sin_s3_r;
  reg sin_r;

  always @(posedge clk_i) begin
    sin_s1_r <= serial_in_i;
    sin_s2_r <= sin_s1_r;
    sin_s3_r <= sin_s2_r;
  end

  always @(posedge clk_i) begin
    if (sin_s2_r == sin_s3_r) begin
      sin_r <= sin_s3_r;
    end
  end

  // ----------------------------------------------------------------
  // Shift decision
  // ----------------------------------------------------------------
  wire sclk_rise;
  wire inhibit_rise;
  wire shift_now;

  assign sclk_rise = pss_rise(sclk_lvl_r, sclk_prev_r);
  assign inhibit_rise = pss_rise(inhibit_lvl_r, inhibit_prev_r);
  // Both rising together matches neither shift case: no shift
  assign shift_now = load_n_r &
    ((sclk_rise & ~inhibit_lvl_r) |
    (inhibit_rise & ~sclk_lvl_r));

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // Deliberately no reset: contents are undefined until the first load
  reg [`PSS_STAGES-1:0] stage_r;
  reg [`PSS_STAGES-1:0] stage_nxt;
  reg out_inv_r;

  always @* begin
    stage_nxt = stage_r;
    if (!load_n_r) begin
      stage_nxt = dat_r;
    end else if (shift_now) begin
      stage_nxt = {sin_r, stage_r[`PSS_FIRST:`PSS_SECOND]};
    end
  end

  always @(posedge clk_i) begin
    stage_r <= stage_nxt;
    out_inv_r <= ~stage_nxt[`PSS_LAST];
  end

  // ----------------------------------------------------------------
  // Serial outputs
  // ----------------------------------------------------------------
  assign serial_out_o = stage_r[`PSS_LAST];
  assign serial_out_complement_o = out_inv_r;

endmodule // pss_shifter
`default_nettype wire

/* design/pss_consts.vh */
// Constants for the parallel-in serial-out shifter.
// Assumes inclusion by its bare name from the design file.
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH

// ----------------------------------------------------------------
// Shape
// ----------------------------------------------------------------
`define PSS_STAGES 8
`define PSS_FIRST 7
`define PSS_SECOND 1
`define PSS_LAST 0

// ----------------------------------------------------------------
// Idle pin levels, also the synchroniser reset values
// ----------------------------------------------------------------
`define PSS_LOAD_IDLE 1'h1
`define PSS_SCLK_IDLE 1'h0
`define PSS_INHIBIT_IDLE 1'h0

// ----------------------------------------------------------------
// Controller clock limits, in MHz
// ----------------------------------------------------------------
`define PSS_FMAX_LIGHT_MHZ 194
`define PSS_FMAX_HEAVY_MHZ 122

`endif

/* verif/pss_props.sv */
// Checker for the shifter: load, shift and output relations on its ports.
// Assumes only the shifter ports; bound into the shifter below.
`timescale 1ns/1ps
`default_nettype none

module pss_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic shift_or_load_n_i,
  input wire logic shift_clock_i,
  input wire logic shift_clock_inhibit_i,
  input wire logic serial_in_i,
  input wire logic [7:0] par_data_i,
  input wire logic serial_out_o,
  input wire logic serial_out_complement_o
);

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------------------------------
  // Shift triggers
  // ----------------------------------------------------------------
  // Pins reach the outputs five edges late, hence the windows below
  sequence s_clock_shift;
    shift_or_load_n_i && !shift_clock_inhibit_i && $rose(shift_clock_i);
  endsequence

  sequence s_inhibit_shift;
    shift_or_load_n_i && !shift_clock_i && $rose(shift_clock_inhibit_i);
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_load_shows_bit: assert property (!shift_or_load_n_i [*6] |->
    serial_out_o == par_data_i[0]) else $error("load value not on output");
  a_load_steady: assert property (!shift_or_load_n_i [*7] |->
    $stable(serial_out_o)) else $error("output moved during load");
  a_comp_is_inverse: assert property (!shift_or_load_n_i [*6] |->
    serial_out_complement_o == !serial_out_o) else $error("complement wrong");
  // Quiet controls for 8 cycles: no pending shift may remain
  a_idle_holds_out: assert property ((shift_or_load_n_i && $stable(shift_clock_i)
    && $stable(shift_clock_inhibit_i)) [*8] |-> $stable(serial_out_o)) else $error("drift");
  a_inhibit_blocks: assert property ((shift_or_load_n_i && shift_clock_inhibit_i) [*8] |->
    $stable(serial_out_o)) else $error("shift while inhibit held high");
  a_clock_shift_inverse: assert property (s_clock_shift |->
    ##6 serial_out_complement_o != serial_out_o) else $error("complement wrong after shift");
  a_inhibit_shift_inverse: assert property (s_inhibit_shift |->
    ##6 serial_out_complement_o != serial_out_o) else $error("complement wrong after shift");

endmodule // pss_props
bind pss_shifter pss_props u_props(.*);
`default_nettype wire

/* verif/pss_ctrl.sv */
// Controller model driving load, shift clock and inhibit pins.
// Assumes the system clock on clk_i; levels change 5 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module pss_ctrl (
  input wire logic clk_i,
  output logic shift_or_load_n_o,
  output logic shift_clock_o,
  output logic shift_clock_inhibit_o
);

  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    shift_or_load_n_o = 1'b1;
    shift_clock_o = 1'b0;
    shift_clock_inhibit_o = 1'b0;
  end

  // Wait n rising edges, then step off the edge
  task automatic wait_edges(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask

  // Levels held 8 cycles: far below the shift clock ceiling
  task automatic do_load();
    wait_edges(3);
    shift_or_load_n_o = 1'b0;
    wait_edges(8);
    shift_or_load_n_o = 1'b1;
    wait_edges(8);
  endtask

  // One shift, by a clock rise or by an inhibit rise with the clock low
  task automatic do_shift(input bit by_inhibit);
    wait_edges(3);
    if (by_inhibit) begin
      shift_clock_inhibit_o = 1'b1;
    end else begin
      shift_clock_o = 1'b1;
    end
    wait_edges(8);
    shift_clock_inhibit_o = 1'b0;
    shift_clock_o = 1'b0;
    wait_edges(8);
  endtask

  // One clock rise shifts; inhibit then blocks its own rise and a second clock rise
  task automatic do_blocked();
    wait_edges(3);
    shift_clock_o = 1'b1;
    wait_edges(8);
    shift_clock_inhibit_o = 1'b1;
    wait_edges(8);
    shift_clock_o = 1'b0;
    wait_edges(8);
    shift_clock_o = 1'b1;
    wait_edges(8);
    shift_clock_o = 1'b0;
    shift_clock_inhibit_o = 1'b0;
    wait_edges(8);
  endtask

endmodule // pss_ctrl
`default_nettype wire

/* verif/parallel_in_serial_out_shifter_bench.sv */
// Bench for the shifter: load, shifts by clock and inhibit, blocked edges.
// Assumes the controller model drives the control pins on a 20 MHz clk_i.
`timescale 1ns/1ps
`default_nettype none

module parallel_in_serial_out_shifter_bench;

  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic serial_in = 1'b0;
  logic [7:0] par_data = 8'ha5;
  wire load_n;
  wire shift_clock;
  wire inhibit;
  wire serial_out;
  wire serial_out_complement;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int k;

  always #25 clk_i = ~clk_i;

  // Ceiling well above the ~290 cycles the tests take
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      test_done();
    end
  end

  pss_ctrl u_ctrl (
    .clk_i(clk_i),
    .shift_or_load_n_o(load_n),
    .shift_clock_o(shift_clock),
    .shift_clock_inhibit_o(inhibit)
  );

  pss_shifter DUT (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .shift_or_load_n_i(load_n),
    .shift_clock_i(shift_clock),
    .shift_clock_inhibit_i(inhibit),
    .serial_in_i(serial_in),
    .par_data_i(par_data),
    .serial_out_o(serial_out),
    .serial_out_complement_o(serial_out_complement)
  );

  task automatic cmp(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Stages have no reset value, so loading comes first
  task automatic t_load();
    u_ctrl.do_load();
    cmp(serial_out, par_data[0]);
    cmp(serial_out_complement, ~par_data[0]);
    $display("load test done");
  endtask

  // Alternate clock and inhibit rises; serial_in shows after 8 shifts
  task automatic t_shift();
    logic exp_bit;
    for (k = 1; k < 12; k++) begin
      serial_in = (k % 3 == 0);
      u_ctrl.do_shift(k[0]);
      exp_bit = (k < 8) ? par_data[k] : ((k - 7) % 3 == 0);
      cmp(serial_out, exp_bit);
      cmp(serial_out_complement, ~exp_bit);
    end
    $display("shift test done");
  endtask

  // Only the first clock rise may shift; the inhibited ones must not
  task automatic t_blocked();
    u_ctrl.do_blocked();
    cmp(serial_out, par_data[1]);
    cmp(serial_out_complement, ~par_data[1]);
    $display("blocked edge test done");
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    #5;
    rstn_i = 1'b1;
    t_load();
    t_shift();
    t_load();
    t_blocked();
    test_done();
  end

endmodule // parallel_in_serial_out_shifter_bench
`default_nettype wire
